// >>> pkg/dcs_pkg.sv
// Constants, types and register map for the dual-channel converter sequencer.
// Assumes one peripheral clock and an AXI4-Lite master with 32-bit data.
// Functional notes
// [R01] Channel bit 0 selects second input, 1 first
// [R02] High byte: 8 MSBs; low byte: 2 LSBs
// [R03] Converter clock is peripheral clock divided by factor
// [R04] Divider factor zero means divide by thirty-two
// [R05] Start bit reads one while conversion runs
// [R06] Result ready eleven converter clocks after start
// [R07] End sets done flag and clears start bit
// [R08] Hardware only sets done flag; software clears it
// [R09] Interrupt request needs converter interrupt enable set
// [R10] Freeze bit with start stalls CPU until end
// [R11] Freeze bit cleared by hardware at conversion end
// [R12] Only CPU core stalls; peripherals keep running
// [R13] Interrupts held pending during stall, serviced after
// [R14] Software sets freeze together with start bit
// [R15] Converter powered only while enable bit set
// [R16] Software waits settle time after enable
// [R17] Clearing enable puts converter in standby
// [R18] Control bit positions fixed; reserved bits read zero
// [R19] Divider register: 5-bit factor, upper bits zero
// [R20] Start write during conversion is ignored
// [R21] Both result bytes update together at end
package dcs_pkg;

  localparam int unsigned DCS_DATA_W = 32;
  localparam int unsigned DCS_RES_W = 10;
  localparam int unsigned DCS_FACT_W = 5;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CLKDIV = 8'hF2;
  localparam logic [7:0] IDX_CTRL = 8'hF3;
  localparam logic [7:0] IDX_RES_LO = 8'hF4;
  localparam logic [7:0] IDX_RES_HI = 8'hF5;
  localparam logic [7:0] IDX_IEN = 8'hF6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_CHAN_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 3;
  localparam int unsigned CTRL_DONE_BIT = 4;
  localparam int unsigned CTRL_EN_BIT = 5;
  localparam int unsigned CTRL_FREEZE_BIT = 6;
  localparam int unsigned IEN_CONV_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------------
  localparam logic [4:0] CLKDIV_RST = 5'h00;
  localparam logic IEN_RST = 1'b0;
  localparam logic [9:0] RES_RST = 10'h000;
  localparam logic [4:0] DIV_ZERO_RELOAD = 5'h1F;
  localparam logic [3:0] CONV_TICKS = 4'hB;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CONV = 3'h4
  } dcs_state_t;

  typedef struct packed {
    logic freeze;
    logic enable;
    logic done;
    logic chan;
  } dcs_ctrl_t;

  typedef struct packed {
    logic powered;
    logic sel_second;
    logic sample;
    logic [9:0] dac_code;
  } dcs_afe_t;

  localparam dcs_ctrl_t CTRL_RST = '0;

endpackage

// >>> hw/dcs_clk_div.sv
// Converter clock divider producing a one-cycle tick per converter period.
// Assumes the factor is stable while run is high.
`timescale 1ns/1ps
module dcs_clk_div import dcs_pkg::*; #(
  parameter int unsigned FW = DCS_FACT_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [FW-1:0] factor,
  output logic tick
);

  logic [FW-1:0] cnt_q;

  if (FW != DCS_FACT_W) begin : g_chk
    $error("dcs_clk_div: factor width must be five");
  end

  function automatic logic [FW-1:0] reload(input logic [FW-1:0] f);
    if (f == '0) begin
      return DIV_ZERO_RELOAD; // [R04]
    end
    return f - {{(FW-1){1'b0}}, 1'b1};
  endfunction

  // ----------------------------------------------------------------------
  // Down counter, restarted whenever run is low
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      cnt_q <= reload(factor);
      tick <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q <= reload(factor); // [R03]
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - {{(FW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

  a_zero_factor: assert property (@(posedge ref_clk) disable iff (srst) // [R04]
    (run && factor == '0 && cnt_q == '0) |=> tick && cnt_q == DIV_ZERO_RELOAD)
    else $error("zero factor did not give a thirty-two cycle period");

endmodule // dcs_clk_div

// >>> hw/dcs_adc_seq.sv
// Converter sequencer: AXI4-Lite registers, SAR sequencing, CPU freeze.
// Assumes an analog front end with sample-hold, DAC and comparator.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dcs_adc_seq import dcs_pkg::*; #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output dcs_afe_t afe_ctl,
  input wire logic comp_above,
  output logic cpu_stall,
  output logic int_hold,
  output logic conv_irq
);

  if (ADDR_W < 10) begin : g_chk
    $error("dcs_adc_seq: address width too small for register map");
  end

  dcs_ctrl_t ctrl_q;
  dcs_state_t state_q;
  logic [4:0] div_q;
  logic ien_q;
  logic [9:0] res_q;
  logic [9:0] sar_q;
  logic [3:0] bit_q;
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_fire;
  logic wr_ok;
  logic wr_ctrl;
  logic busy;
  logic tick;
  logic start_ok;
  logic finish;
  logic abort;
  logic [3:0] tick_cnt_q;

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready = !w_got_q;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_ok = is_reg(awaddr_q, IDX_CTRL) || is_reg(awaddr_q, IDX_CLKDIV)
    || is_reg(awaddr_q, IDX_IEN);
  assign wr_ctrl = wr_fire && wstrb_q[0] && is_reg(awaddr_q, IDX_CTRL);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && !aw_got_q) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && !w_got_q) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_q <= CLKDIV_RST;
      ien_q <= IEN_RST;
    end else if (wr_fire && wstrb_q[0]) begin
      if (is_reg(awaddr_q, IDX_CLKDIV)) begin
        div_q <= wdata_q[4:0]; // [R19]
      end
      if (is_reg(awaddr_q, IDX_IEN)) begin
        ien_q <= wdata_q[IEN_CONV_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.chan <= wdata_q[CTRL_CHAN_BIT];
        ctrl_q.enable <= wdata_q[CTRL_EN_BIT];
        ctrl_q.done <= wdata_q[CTRL_DONE_BIT]; // [R08]
        if (state_q == ST_IDLE) begin
          ctrl_q.freeze <= wdata_q[CTRL_FREEZE_BIT]; // [R14]
        end
      end
      if (finish) begin
        ctrl_q.done <= 1'b1; // [R07] [R08]
        ctrl_q.freeze <= 1'b0; // [R11]
      end
      if (abort) begin
        ctrl_q.freeze <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------------
  assign busy = state_q != ST_IDLE;
  assign start_ok = wr_ctrl && wdata_q[CTRL_START_BIT] && wdata_q[CTRL_EN_BIT]
    && state_q == ST_IDLE; // [R20]
  assign finish = state_q == ST_CONV && tick && bit_q == '0;
  assign abort = busy && !ctrl_q.enable; // [R17]

  dcs_clk_div #(
    .FW(DCS_FACT_W)
  ) u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(busy),
    .factor(div_q),
    .tick(tick)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (abort) begin
            state_q <= ST_IDLE;
          end else if (tick) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abort || finish) begin
            state_q <= ST_IDLE; // [R06]
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sar_q <= '0;
      bit_q <= '0;
    end else if (start_ok) begin
      sar_q <= '0;
      bit_q <= SAR_TOP_BIT;
    end else if (tick && state_q == ST_SAMPLE) begin
      sar_q <= SAR_FIRST_TRIAL;
    end else if (tick && state_q == ST_CONV) begin
      sar_q[bit_q] <= comp_above;
      if (bit_q != '0) begin
        sar_q[bit_q - 4'h1] <= 1'b1;
        bit_q <= bit_q - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      res_q <= RES_RST;
    end else if (finish) begin
      res_q <= {sar_q[9:1], comp_above}; // [R21]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || start_ok) begin
      tick_cnt_q <= '0;
    end else if (tick && busy) begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Front end, core and interrupt controls
  // ----------------------------------------------------------------------
  assign afe_ctl.powered = ctrl_q.enable; // [R15] [R17]
  assign afe_ctl.sel_second = !ctrl_q.chan; // [R01]
  assign afe_ctl.sample = state_q == ST_SAMPLE;
  assign afe_ctl.dac_code = sar_q;
  assign cpu_stall = ctrl_q.freeze && busy; // [R10] [R12]
  assign int_hold = cpu_stall; // [R13]
  assign conv_irq = ctrl_q.done && ien_q; // [R09]

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    if (is_reg(s_axi_araddr, IDX_CTRL)) begin
      rd_val[CTRL_CHAN_BIT] = ctrl_q.chan; // [R18]
      rd_val[CTRL_START_BIT] = busy; // [R05]
      rd_val[CTRL_DONE_BIT] = ctrl_q.done;
      rd_val[CTRL_EN_BIT] = ctrl_q.enable;
      rd_val[CTRL_FREEZE_BIT] = ctrl_q.freeze;
    end else if (is_reg(s_axi_araddr, IDX_CLKDIV)) begin
      rd_val[4:0] = div_q; // [R19]
    end else if (is_reg(s_axi_araddr, IDX_RES_HI)) begin
      rd_val[7:0] = res_q[9:2]; // [R02]
    end else if (is_reg(s_axi_araddr, IDX_RES_LO)) begin
      rd_val[1:0] = res_q[1:0]; // [R02]
    end else if (is_reg(s_axi_araddr, IDX_IEN)) begin
      rd_val[IEN_CONV_BIT] = ien_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_chan_select: assert property (@(posedge ref_clk) disable iff (srst) // [R01]
    afe_ctl.sel_second == !ctrl_q.chan)
    else $error("channel select inverted");
  a_result_split: assert property (@(posedge ref_clk) disable iff (srst) // [R02]
    finish |=> res_q[9:2] == $past(sar_q[9:2]) && res_q[0] == $past(comp_above))
    else $error("result bytes not loaded from sample");
  a_conv_length: assert property (@(posedge ref_clk) disable iff (srst) // [R06]
    finish |-> (tick_cnt_q + 4'h1) == CONV_TICKS)
    else $error("conversion not eleven converter clocks");
  a_end_flags: assert property (@(posedge ref_clk) disable iff (srst) // [R07]
    finish |=> ctrl_q.done && !busy && !ctrl_q.freeze)
    else $error("end of conversion flags wrong");
  a_done_sticky: assert property (@(posedge ref_clk) disable iff (srst) // [R08]
    (ctrl_q.done && !wr_ctrl) |=> ctrl_q.done)
    else $error("done flag cleared by hardware");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (srst) // [R09]
    conv_irq == (ctrl_q.done && ien_q))
    else $error("interrupt request not gated by enable");
  a_stall_span: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
    (start_ok && wdata_q[CTRL_FREEZE_BIT]) |=> cpu_stall && int_hold)
    else $error("core not stalled at launch");
  a_power_follow: assert property (@(posedge ref_clk) disable iff (srst) // [R15]
    $fell(ctrl_q.enable) |-> !afe_ctl.powered ##1 !busy)
    else $error("converter not put in standby");
  a_no_restart: assert property (@(posedge ref_clk) disable iff (srst) // [R20]
    (state_q == ST_CONV && wr_ctrl && ctrl_q.enable && wdata_q[CTRL_EN_BIT])
    |=> state_q != ST_SAMPLE)
    else $error("running conversion restarted");

endmodule // dcs_adc_seq

// >>> test/dcs_afe_model.sv
// Behavioural analog front end: sample-hold, trial DAC and comparator.
// Assumes the sequencer keeps a trial bit while comp_above is high.
`timescale 1ns/1ps
module dcs_afe_model import dcs_pkg::*; (
  input wire logic ref_clk,
  input dcs_afe_t afe_ctl,
  input wire logic [9:0] ain_first,
  input wire logic [9:0] ain_second,
  output logic comp_above
);
  logic [9:0] held_q = 10'h000;
  logic flip_q = 1'b0;

  // Hold the selected input while sampling
  always_ff @(posedge ref_clk) begin
    if (afe_ctl.sample) begin
      held_q <= afe_ctl.sel_second ? ain_second : ain_first;
    end
  end

  // Unpowered comparator output is not trustworthy
  always_ff @(posedge ref_clk) begin
    flip_q <= !flip_q;
  end

  assign comp_above = afe_ctl.powered ? (held_q >= afe_ctl.dac_code) : flip_q;
endmodule // dcs_afe_model

// >>> test/testbench.sv
// Self-checking bench for the converter sequencer over AXI4-Lite.
// Assumes the behavioural front end model closes the comparator loop.
`timescale 1ns/1ps
module testbench import dcs_pkg::*; ;
  localparam int SETTLE = 20;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  dcs_afe_t afe_ctl;
  logic comp_above, cpu_stall, int_hold, conv_irq;
  logic [9:0] ain_first = 10'h2A5;
  logic [9:0] ain_second = 10'h15A;
  int num_errors = 0;
  int cmp_count = 0;
  int stall_cnt = 0;
  int stall_len = 0;

  dcs_adc_seq i_dut (
    .ref_clk(ref_clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .afe_ctl(afe_ctl), .comp_above(comp_above),
    .cpu_stall(cpu_stall), .int_hold(int_hold), .conv_irq(conv_irq)
  );

  dcs_afe_model i_afe (
    .ref_clk(ref_clk), .afe_ctl(afe_ctl),
    .ain_first(ain_first), .ain_second(ain_second), .comp_above(comp_above)
  );

  initial begin
    forever #2.5 ref_clk = !ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [11:0] adr(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'h3;
    @(posedge ref_clk);
    s_axi_awaddr <= adr(i);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (r === 2'h3) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    chk(r, er);
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    d = 32'h0;
    @(posedge ref_clk);
    s_axi_araddr <= adr(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (r === 2'h3) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, exp);
    chk(r, er);
  endtask

  task automatic conv(input logic chan, input logic [4:0] f, input logic [9:0] v);
    logic [31:0] d;
    logic [1:0] r;
    int fe;
    fe = (f == 5'h00) ? 32 : int'(f);
    wr(IDX_CLKDIV, {27'h0, f}, RESP_OKAY);
    wr(IDX_CTRL, 32'h68 | chan, RESP_OKAY);
    rdc(IDX_CTRL, 32'h68 | chan, RESP_OKAY);
    chk(cpu_stall, 1'b1);
    chk(afe_ctl.sel_second, !chan);
    wr(IDX_CTRL, 32'h28 | chan, RESP_OKAY);
    d = 32'h8;
    for (int n = 0; n < 400 && d[3] !== 1'b0; n++) rd(IDX_CTRL, d, r);
    chk(d, 32'h30 | chan);
    chk(stall_len >= 11 * fe && stall_len <= 11 * fe + 3, 1'b1);
    rdc(IDX_RES_HI, {24'h0, v[9:2]}, RESP_OKAY);
    rdc(IDX_RES_LO, {30'h0, v[1:0]}, RESP_OKAY);
  endtask

  // Length of each stall window, and interrupt holding follows it
  always @(posedge ref_clk) begin
    if (cpu_stall === 1'b1) begin
      stall_cnt <= stall_cnt + 1;
    end else if (stall_cnt != 0) begin
      stall_len <= stall_cnt;
      stall_cnt <= 0;
    end
    if (!srst && int_hold !== cpu_stall) chk(int_hold, cpu_stall);
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 8'hF2; i <= 8'hF6; i++) rdc(8'(i), 32'h0, RESP_OKAY);
    chk(afe_ctl, 13'h0800);
    wr(IDX_CLKDIV, 32'hFF, RESP_OKAY);
    rdc(IDX_CLKDIV, 32'h1F, RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(IDX_CLKDIV, 32'h05, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdc(IDX_CLKDIV, 32'h1F, RESP_OKAY);
    wr(IDX_CTRL, 32'hA7, RESP_OKAY);
    rdc(IDX_CTRL, 32'h21, RESP_OKAY);
    chk(afe_ctl.powered, 1'b1);
    wr(IDX_RES_HI, 32'hFF, RESP_SLVERR);
    wr(8'h10, 32'h1, RESP_SLVERR);
    rdc(8'h10, 32'h0, RESP_SLVERR);
    wr(IDX_CTRL, 32'h20, RESP_OKAY);
    repeat (SETTLE) @(posedge ref_clk);
    conv(1'b0, 5'h03, ain_second);
    wr(IDX_CTRL, 32'h20, RESP_OKAY);
    rdc(IDX_CTRL, 32'h20, RESP_OKAY);
    conv(1'b1, 5'h00, ain_first);
    chk(conv_irq, 1'b0);
    wr(IDX_IEN, 32'h1, RESP_OKAY);
    rdc(IDX_IEN, 32'h1, RESP_OKAY);
    chk(conv_irq, 1'b1);
    wr(IDX_CTRL, 32'h21, RESP_OKAY);
    chk(conv_irq, 1'b0);
    wr(IDX_CTRL, 32'h29, RESP_OKAY);
    wr(IDX_CTRL, 32'h01, RESP_OKAY);
    chk(afe_ctl.powered, 1'b0);
    rdc(IDX_CTRL, 32'h01, RESP_OKAY);
    rdc(IDX_RES_HI, {24'h0, ain_first[9:2]}, RESP_OKAY);
    wr(IDX_CTRL, 32'h09, RESP_OKAY);
    rdc(IDX_CTRL, 32'h01, RESP_OKAY);
    results();
  end

  initial begin
    #100us;
    num_errors++;
    results();
  end
endmodule // testbench
